//--- core/serial_pkg.sv
// package: register map, field layouts, commands and carriers of the dual-channel serial block
package serial_pkg;

    // ****************************************
    // register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [11:0] IDX_OUT_SET    = 12'h71E;
    localparam logic [11:0] IDX_OUT_CLR    = 12'h71F;
    localparam logic [11:0] IDX_CMD_A      = 12'h700;
    localparam logic [11:0] IDX_CMD_B      = 12'h701;
    localparam logic [11:0] IDX_MODE1_A    = 12'h702;
    localparam logic [11:0] IDX_MODE1_B    = 12'h703;
    localparam logic [11:0] IDX_CLKSEL     = 12'h704;
    localparam logic [11:0] IDX_TXDATA_A   = 12'h705;
    localparam logic [11:0] IDX_TXDATA_B   = 12'h706;
    localparam logic [11:0] IDX_STATUS     = 12'h707;
    localparam logic [11:0] IDX_IRQ_STAT   = 12'h708;
    localparam logic [11:0] IDX_IRQ_CLR    = 12'h709;
    localparam logic [11:0] IDX_IRQ_EN     = 12'h70A;
    localparam logic [11:0] IDX_RX_LEVEL   = 12'h70B;

    // ****************************************
    // command register field (bits 6:4) and codes
    // ****************************************
    localparam int          CMD_LSB        = 4;
    localparam logic [2:0]  CMD_NONE       = 3'h0;
    localparam logic [2:0]  CMD_ASSERT_RTS = 3'h1;
    localparam logic [2:0]  CMD_NEGATE_RTS = 3'h2;
    localparam logic [2:0]  CMD_TX_ENABLE  = 3'h3;
    localparam logic [2:0]  CMD_TX_DISABLE = 3'h4;

    // ****************************************
    // mode register one fields
    // ****************************************
    localparam int          M1_ADDR_DATA   = 2;
    localparam int          M1_MULTIDROP   = 3;
    localparam int          M1_RX_FLOW     = 7;
    localparam int          M1_TX_FLOW     = 6;
    localparam logic [7:0]  M1_RESET       = 8'h00;

    // ****************************************
    // clock select fields per channel: [1:0] source
    // ****************************************
    localparam logic [1:0]  SRC_XTAL_16X   = 2'h0;
    localparam logic [1:0]  SRC_EXT_1X     = 2'h1;
    localparam logic [1:0]  SRC_EXT_16X    = 2'h2;
    localparam logic [7:0]  CLKSEL_RESET   = 8'h00;

    // ****************************************
    // interrupt bits per channel (stride 2)
    // ****************************************
    localparam int          IRQ_TX_READY   = 0;
    localparam int          IRQ_TX_DONE    = 1;

    // ****************************************
    // timing
    // ****************************************
    localparam int          STOP_BITS      = 1;
    localparam int          FRAME_BITS_MD  = 11;
    localparam logic [15:0] XTAL_DIV_RESET = 16'h0018;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic [1:0] src;
        logic       md_en;
        logic       ad_flag;
    } tx_cfg_t;

endpackage : serial_pkg

//--- core/serial_tx_chan.sv
// module: one transmit channel with holding buffer, shift register and multidrop flag latch
`timescale 1ns/10ps
`default_nettype none
module serial_tx_chan (
    input  wire logic                I_CLK,
    input  wire logic                I_RST,
    input  wire logic                I_CE,
    input  wire logic                I_EN,
    input  wire serial_pkg::tx_cfg_t I_CFG,
    input  wire logic                I_TICK16,
    input  wire logic                I_EXT_RISE,
    input  wire logic                I_WR,
    input  wire logic [7:0]          I_DATA,
    output logic                     O_HOLD_FREE,
    output logic                     O_EMPTY,
    output logic                     O_LOAD,
    output logic                     O_DONE,
    output logic                     O_TXD
);
    import serial_pkg::*;

    typedef enum {IDLE, SHIFT} state_t;

    state_t      state_ff,  nxt_state;
    logic [7:0]  hold_ff,   nxt_hold;
    logic        full_ff,   nxt_full;
    logic [10:0] sh_ff,     nxt_sh;
    logic [3:0]  cnt_ff,    nxt_cnt;
    logic [3:0]  sub_ff,    nxt_sub;
    logic        txd_ff,    nxt_txd;
    logic        load_ff,   nxt_load;
    logic        done_ff,   nxt_done;
    logic        bit_tick;

    // ****************************************
    // bit timing: crystal or external clock, 1x or 16x
    // ****************************************
    always_comb begin
        nxt_sub = sub_ff;
        bit_tick = 1'b0;
        if (I_CFG.src == SRC_EXT_1X) begin
            bit_tick = I_EXT_RISE;
        end else if (I_TICK16) begin
            nxt_sub = sub_ff + 4'h1;
            bit_tick = (sub_ff == 4'hF);
        end
        if (state_ff == IDLE) begin
            nxt_sub = 4'h0;
        end
    end

    // ****************************************
    // frame sequencer
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_hold  = hold_ff;
        nxt_full  = full_ff;
        nxt_sh    = sh_ff;
        nxt_cnt   = cnt_ff;
        nxt_txd   = txd_ff;
        nxt_load  = 1'b0;
        nxt_done  = 1'b0;
        if (I_WR && !full_ff) begin
            nxt_hold = I_DATA;
            nxt_full = 1'b1;
        end
        case (state_ff)
            IDLE: begin
                nxt_txd = 1'b1;
                if (full_ff && I_EN) begin
                    // flag latched with the character at transfer time
                    nxt_sh    = {1'b1, I_CFG.md_en ? I_CFG.ad_flag : 1'b1, hold_ff, 1'b0};
                    nxt_full  = 1'b0;
                    nxt_load  = 1'b1;
                    nxt_cnt   = I_CFG.md_en ? 4'(FRAME_BITS_MD) : 4'(FRAME_BITS_MD - 1);
                    nxt_state = SHIFT;
                end
            end
            SHIFT: begin
                if (bit_tick) begin
                    nxt_txd = sh_ff[0];
                    nxt_sh  = {1'b1, sh_ff[10:1]};
                    nxt_cnt = cnt_ff - 4'h1;
                    if (cnt_ff == 4'h0) begin
                        // last stop bit has fully elapsed
                        nxt_txd   = 1'b1;
                        nxt_done  = !full_ff;
                        nxt_state = IDLE;
                    end
                end
            end
            default: nxt_state = IDLE;
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            state_ff <= IDLE;
            hold_ff  <= 8'h00;
            full_ff  <= 1'b0;
            sh_ff    <= 11'h7FF;
            cnt_ff   <= 4'h0;
            sub_ff   <= 4'h0;
            txd_ff   <= 1'b1;
            load_ff  <= 1'b0;
            done_ff  <= 1'b0;
        end else if (I_CE) begin
            state_ff <= nxt_state;
            hold_ff  <= nxt_hold;
            full_ff  <= nxt_full;
            sh_ff    <= nxt_sh;
            cnt_ff   <= nxt_cnt;
            sub_ff   <= nxt_sub;
            txd_ff   <= nxt_txd;
            load_ff  <= nxt_load;
            done_ff  <= nxt_done;
        end
    end

    assign O_HOLD_FREE = !full_ff;
    assign O_EMPTY     = !full_ff && (state_ff == IDLE);
    assign O_LOAD      = load_ff;
    assign O_DONE      = done_ff;
    assign O_TXD       = txd_ff;
endmodule : serial_tx_chan
`default_nettype wire

//--- core/serial_rts_baud_multidrop.sv
// module: dual-channel serial block with request-to-send control, baud sourcing and multidrop
//
// What this block does
// - request-to-send pins are active low: 0 when set, 1 when cleared.
// - writing one to an output-set bit sets that channel's request-to-send.
// - writing one to an output-clear bit clears that channel's request-to-send.
// - assert command in channel command register sets request-to-send.
// - negate command in channel command register clears request-to-send.
// - reset clears every request-to-send, pins drive high.
// - receiver flow on: receive FIFO leaving full sets request-to-send.
// - receiver flow on: receive FIFO becoming full clears request-to-send.
// - transmit flow on: clear request-to-send after last character's stop bits.
// - receiver flow control works without a first manual assertion.
// - crystal-sourced baud rates scale in proportion to crystal frequency.
// - one external baud clock serves both channels, each 1x or 16x.
// - multidrop flag latched into character at holding-to-shift transfer.
// - transmit-ready asserts at transfer; later flag changes don't affect it.
// - flag changes need no transmitter disable nor empty wait.
`timescale 1ns/10ps
`default_nettype none
module serial_rts_baud_multidrop #(
    parameter int RX_DEPTH = 4
) (
    input  wire logic                  I_SYS_CLK,
    input  wire logic                  I_SYS_RST,
    input  wire logic                  I_CE,
    input  wire serial_pkg::reg_req_t  I_REG,
    output logic [7:0]                 O_RDATA,
    output logic                       O_IRQ,
    input  wire logic                  I_CRYSTAL_INPUT,
    input  wire logic                  I_EXT_BAUD_CLK,
    input  wire logic [1:0]            I_RXD,
    input  wire logic [1:0]            I_RX_POP,
    output logic [1:0]                 O_TXD,
    output logic [1:0]                 O_REQUEST_TO_SEND_N,
    output logic [1:0]                 O_TRANSMIT_HOLDING_FREE,
    output logic [1:0]                 O_TRANSMITTER_FULLY_EMPTY
);
    import serial_pkg::*;

    if (RX_DEPTH < 1 || RX_DEPTH > 15) begin : g_bad_depth
        $error("RX_DEPTH must be 1..15");
    end

    // ****************************************
    // pin synchronisers: three stages, change accepted when last two agree
    // ****************************************
    logic [2:0] xs_ff, es_ff;
    logic       xtal_ff, ext_ff, xtal_prev_ff, ext_prev_ff;
    logic       nxt_xtal, nxt_ext;
    logic       xtal_rise, ext_rise;
    logic [5:0] rxs_ff;
    logic [1:0] rx_lvl_ff, nxt_rx_lvl;

    always_comb begin
        nxt_xtal = (xs_ff[2] == xs_ff[1]) ? xs_ff[2] : xtal_ff;
        nxt_ext  = (es_ff[2] == es_ff[1]) ? es_ff[2] : ext_ff;
        nxt_rx_lvl = (rxs_ff[3:2] & rxs_ff[5:4]) | ((rxs_ff[3:2] ^ rxs_ff[5:4]) & rx_lvl_ff);
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            xs_ff        <= 3'h0;
            es_ff        <= 3'h0;
            rxs_ff       <= 6'h3F;
            rx_lvl_ff    <= 2'h3;
            xtal_ff      <= 1'b0;
            ext_ff       <= 1'b0;
            xtal_prev_ff <= 1'b0;
            ext_prev_ff  <= 1'b0;
        end else if (I_CE) begin
            xs_ff        <= {xs_ff[1:0], I_CRYSTAL_INPUT};
            es_ff        <= {es_ff[1:0], I_EXT_BAUD_CLK};
            rxs_ff       <= {rxs_ff[3:0], I_RXD};
            rx_lvl_ff    <= nxt_rx_lvl;
            xtal_ff      <= nxt_xtal;
            ext_ff       <= nxt_ext;
            xtal_prev_ff <= xtal_ff;
            ext_prev_ff  <= ext_ff;
        end
    end

    // crystal edges only land correctly while the system clock is fast enough
    assign xtal_rise = xtal_ff && !xtal_prev_ff;
    assign ext_rise  = ext_ff && !ext_prev_ff;

    // ****************************************
    // registers
    // ****************************************
    logic [7:0]  mode1_ff [2];
    logic [7:0]  nxt_mode1 [2];
    logic [7:0]  clksel_ff, nxt_clksel;
    logic [15:0] divcnt_ff, nxt_divcnt;
    logic        tick16_ff, nxt_tick16;
    logic [1:0]  txen_ff, nxt_txen;
    logic [3:0]  irq_stat_ff, nxt_irq_stat;
    logic [3:0]  irq_en_ff, nxt_irq_en;
    logic [7:0]  rdata_ff, nxt_rdata;
    logic [1:0]  rts_ff, nxt_rts;
    logic [3:0]  rxcnt_ff [2];
    logic [3:0]  nxt_rxcnt [2];
    logic [1:0]  rxfull_prev_ff;
    logic [1:0]  hold_free, empty, load, done;
    logic [1:0]  rx_full, rx_in, rx_was_full;
    logic        wr_set, wr_clr;
    logic [1:0]  wr_cmd, wr_tx;

    assign wr_set    = I_REG.wr && I_REG.addr == IDX_OUT_SET;
    assign wr_clr    = I_REG.wr && I_REG.addr == IDX_OUT_CLR;
    assign wr_cmd[0] = I_REG.wr && I_REG.addr == IDX_CMD_A;
    assign wr_cmd[1] = I_REG.wr && I_REG.addr == IDX_CMD_B;
    assign wr_tx[0]  = I_REG.wr && I_REG.addr == IDX_TXDATA_A;
    assign wr_tx[1]  = I_REG.wr && I_REG.addr == IDX_TXDATA_B;

    // ****************************************
    // shared crystal divider for the 16x reference
    // ****************************************
    always_comb begin
        nxt_divcnt = divcnt_ff;
        nxt_tick16 = 1'b0;
        // rates follow the crystal edge rate, so halving it halves every crystal-sourced rate
        if (xtal_rise) begin
            if (divcnt_ff >= XTAL_DIV_RESET) begin
                nxt_divcnt = 16'h0001;
                nxt_tick16 = 1'b1;
            end else begin
                nxt_divcnt = divcnt_ff + 16'h0001;
            end
        end
    end

    // ****************************************
    // per-channel logic
    // ****************************************
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            tx_cfg_t cfg;
            logic    tick;

            assign cfg.src     = clksel_ff[ch*4 +: 2];
            assign cfg.md_en   = mode1_ff[ch][M1_MULTIDROP];
            assign cfg.ad_flag = mode1_ff[ch][M1_ADDR_DATA];
            // external clock in 16x mode, crystal divider otherwise
            assign tick = (cfg.src == SRC_EXT_16X) ? ext_rise : tick16_ff;

            // flag is only sampled at transfer, so it may change any time
            serial_tx_chan u_tx (
                .I_CLK       (I_SYS_CLK),
                .I_RST       (I_SYS_RST),
                .I_CE        (I_CE),
                .I_EN        (txen_ff[ch]),
                .I_CFG       (cfg),
                .I_TICK16    (tick),
                .I_EXT_RISE  (ext_rise),
                .I_WR        (wr_tx[ch]),
                .I_DATA      (I_REG.wdata),
                .O_HOLD_FREE (hold_free[ch]),
                .O_EMPTY     (empty[ch]),
                .O_LOAD      (load[ch]),
                .O_DONE      (done[ch]),
                .O_TXD       (O_TXD[ch])
            );

            // receive occupancy: a synchronised falling edge counts as one arrival
            assign rx_in[ch]       = rx_lvl_ff[ch] && !nxt_rx_lvl[ch];
            assign rx_full[ch]     = rxcnt_ff[ch] == 4'(RX_DEPTH);
            assign rx_was_full[ch] = rxfull_prev_ff[ch];

            always_comb begin
                nxt_rxcnt[ch] = rxcnt_ff[ch];
                if (rx_in[ch] && !rx_full[ch]) begin
                    nxt_rxcnt[ch] = rxcnt_ff[ch] + 4'h1;
                end else if (I_RX_POP[ch] && rxcnt_ff[ch] != 4'h0) begin
                    nxt_rxcnt[ch] = rxcnt_ff[ch] - 4'h1;
                end
            end
        end
    endgenerate

    // ****************************************
    // request-to-send state
    // ****************************************
    always_comb begin
        logic [1:0] set_src;
        logic [1:0] clr_src;
        set_src = 2'h0;
        clr_src = 2'h0;
        for (int c = 0; c < 2; c++) begin
            set_src[c] = (wr_set && I_REG.wdata[c])
                || (wr_cmd[c] && I_REG.wdata[CMD_LSB +: 3] == CMD_ASSERT_RTS)
                // edge of the full flag alone drives it, no priming needed
                || (mode1_ff[c][M1_RX_FLOW] && rx_was_full[c] && !rx_full[c]);
            clr_src[c] = (wr_clr && I_REG.wdata[c])
                || (wr_cmd[c] && I_REG.wdata[CMD_LSB +: 3] == CMD_NEGATE_RTS)
                || (mode1_ff[c][M1_RX_FLOW] && !rx_was_full[c] && rx_full[c])
                || (mode1_ff[c][M1_TX_FLOW] && done[c]);
        end
        nxt_rts = (rts_ff | set_src) & ~clr_src;
    end

    // ****************************************
    // configuration, interrupts and read path
    // ****************************************
    always_comb begin
        nxt_mode1    = mode1_ff;
        nxt_clksel   = clksel_ff;
        nxt_txen     = txen_ff;
        nxt_irq_en   = irq_en_ff;
        nxt_rdata    = 8'h00;
        // set wins over clear in the same cycle
        nxt_irq_stat = irq_stat_ff & ~((I_REG.wr && I_REG.addr == IDX_IRQ_CLR) ? I_REG.wdata[3:0] : 4'h0);
        nxt_irq_stat = nxt_irq_stat | {done[1], load[1], done[0], load[0]};
        for (int c = 0; c < 2; c++) begin
            if (wr_cmd[c] && I_REG.wdata[CMD_LSB +: 3] == CMD_TX_ENABLE) begin
                nxt_txen[c] = 1'b1;
            end
            if (wr_cmd[c] && I_REG.wdata[CMD_LSB +: 3] == CMD_TX_DISABLE) begin
                nxt_txen[c] = 1'b0;
            end
        end
        if (I_REG.wr) begin
            case (I_REG.addr)
                IDX_MODE1_A: nxt_mode1[0] = I_REG.wdata;
                IDX_MODE1_B: nxt_mode1[1] = I_REG.wdata;
                IDX_CLKSEL:  nxt_clksel   = I_REG.wdata;
                IDX_IRQ_EN:  nxt_irq_en   = I_REG.wdata[3:0];
                default:     ;
            endcase
        end
        if (I_REG.rd) begin
            case (I_REG.addr)
                IDX_MODE1_A:  nxt_rdata = mode1_ff[0];
                IDX_MODE1_B:  nxt_rdata = mode1_ff[1];
                IDX_CLKSEL:   nxt_rdata = clksel_ff;
                IDX_STATUS:   nxt_rdata = {txen_ff, ~O_REQUEST_TO_SEND_N, rx_full, hold_free};
                IDX_IRQ_STAT: nxt_rdata = {4'h0, irq_stat_ff};
                IDX_IRQ_EN:   nxt_rdata = {4'h0, irq_en_ff};
                IDX_RX_LEVEL: nxt_rdata = {rxcnt_ff[1], rxcnt_ff[0]};
                default:      nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            mode1_ff       <= '{M1_RESET, M1_RESET};
            clksel_ff      <= CLKSEL_RESET;
            divcnt_ff      <= 16'h0001;
            tick16_ff      <= 1'b0;
            txen_ff        <= 2'h0;
            irq_stat_ff    <= 4'h0;
            irq_en_ff      <= 4'h0;
            rdata_ff       <= 8'h00;
            rts_ff         <= 2'h0;
            rxcnt_ff       <= '{4'h0, 4'h0};
            rxfull_prev_ff <= 2'h0;
        end else if (I_CE) begin
            mode1_ff       <= nxt_mode1;
            clksel_ff      <= nxt_clksel;
            divcnt_ff      <= nxt_divcnt;
            tick16_ff      <= nxt_tick16;
            txen_ff        <= nxt_txen;
            irq_stat_ff    <= nxt_irq_stat;
            irq_en_ff      <= nxt_irq_en;
            rdata_ff       <= nxt_rdata;
            rts_ff         <= nxt_rts;
            rxcnt_ff       <= nxt_rxcnt;
            rxfull_prev_ff <= rx_full;
        end
    end

    assign O_REQUEST_TO_SEND_N       = ~rts_ff;
    assign O_RDATA                   = rdata_ff;
    assign O_IRQ                     = |(irq_stat_ff & irq_en_ff);
    assign O_TRANSMIT_HOLDING_FREE   = hold_free;
    assign O_TRANSMITTER_FULLY_EMPTY = empty;
endmodule : serial_rts_baud_multidrop
`default_nettype wire

//--- verif/serial_rts_baud_multidrop_sva.sv
// checker: port assertions for the serial request-to-send block
`timescale 1ns/10ps
`default_nettype none
module serial_rts_checker #(
    parameter int RX_DEPTH = 4
) (
    input wire logic                 I_SYS_CLK,
    input wire logic                 I_SYS_RST,
    input wire serial_pkg::reg_req_t I_REG,
    input wire logic [7:0]           O_RDATA,
    input wire logic [1:0]           O_REQUEST_TO_SEND_N,
    input wire logic [1:0]           O_TRANSMIT_HOLDING_FREE,
    input wire logic [1:0]           O_TRANSMITTER_FULLY_EMPTY
);
    import serial_pkg::*;
    logic [1:0] rts_n;
    logic [1:0] hfree;
    logic       wr;
    assign rts_n = O_REQUEST_TO_SEND_N;
    assign hfree = O_TRANSMIT_HOLDING_FREE;
    assign wr    = I_REG.wr;
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);
    // ****************************************
    // request-to-send, read port, transmitter
    // ****************************************
    rst_clears_a: assert property (disable iff (1'b0) I_SYS_RST |=> rts_n == 2'h3)
        else $error("reset left rts set");
    set_write_a: assert property (wr && I_REG.addr == IDX_OUT_SET && I_REG.wdata[0] |=> !rts_n[0])
        else $error("set write ignored");
    clr_write_a: assert property (wr && I_REG.addr == IDX_OUT_CLR && I_REG.wdata[1] |=> rts_n[1])
        else $error("clear write ignored");
    cmd_assert_a: assert property (wr && I_REG.addr == IDX_CMD_B && I_REG.wdata[6:4] == CMD_ASSERT_RTS |=> !rts_n[1])
        else $error("assert command ignored");
    cmd_negate_a: assert property (wr && I_REG.addr == IDX_CMD_A && I_REG.wdata[6:4] == CMD_NEGATE_RTS |=> rts_n[0])
        else $error("negate command ignored");
    rdata_idle_a: assert property (!I_REG.rd |=> O_RDATA == 8'h00)
        else $error("stray read data");
    hold_fall_a: assert property (wr && I_REG.addr == IDX_TXDATA_A && hfree[0]
        |=> !hfree[0] && !O_TRANSMITTER_FULLY_EMPTY[0]) else $error("holding buffer not taken");
    load_busy_a: assert property ($rose(hfree[0]) |-> !O_TRANSMITTER_FULLY_EMPTY[0])
        else $error("ready without shifting");
    cover property (wr && I_REG.addr == IDX_OUT_SET);
    cover property ($rose(hfree[0]));
    cover property ($rose(rts_n[0]) && O_TRANSMITTER_FULLY_EMPTY[0]);
endmodule : serial_rts_checker
bind serial_rts_baud_multidrop serial_rts_checker #(.RX_DEPTH(RX_DEPTH)) i_chk (
    .I_SYS_CLK, .I_SYS_RST, .I_REG, .O_RDATA, .O_REQUEST_TO_SEND_N,
    .O_TRANSMIT_HOLDING_FREE, .O_TRANSMITTER_FULLY_EMPTY
);
`default_nettype wire

//--- verif/remote_serial_peer.sv
// partner: remote peer that decodes both transmit lines and sends receive characters
`timescale 1ns/10ps
`default_nettype none
module remote_serial_peer (
    input  wire logic        i_clk,
    input  wire logic        i_ext_baud,
    input  wire logic [1:0]  i_txd,
    input  wire logic [1:0]  i_send,
    output logic      [1:0]  o_rxd,
    output logic      [10:0] o_frame [2],
    output logic      [7:0]  o_count [2]
);
    for (genvar c = 0; c < 2; c++) begin : g_ch
        localparam int DIV = (c == 0) ? 1 : 16;
        logic rxd = 1'b1;
        assign o_rxd[c] = rxd;
        // mid-bit sampling on falling baud edges
        initial begin
            logic [10:0] bits;
            o_count[c] = 8'h00;
            o_frame[c] = 11'h000;
            forever begin
                @(negedge i_txd[c]);
                for (int n = 0; n < 11; n++) begin
                    repeat ((n == 0) ? (DIV + 1) / 2 : DIV) @(negedge i_ext_baud);
                    bits[n] = i_txd[c];
                end
                o_frame[c] = bits;
                o_count[c] = o_count[c] + 8'h01;
            end
        end
        // four-clock low pulse is one character
        always @(posedge i_clk) begin
            if (i_send[c]) begin
                rxd <= 1'b0;
                repeat (4) @(posedge i_clk);
                rxd <= 1'b1;
            end
        end
    end
endmodule : remote_serial_peer
`default_nettype wire

//--- verif/tb_top.sv
// testbench: request-to-send control, baud sourcing and multidrop marking
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import serial_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ext = 1'b0;
    reg_req_t    req = '0;
    logic [1:0]  pop = 2'h0;
    logic [1:0]  send = 2'h0;
    logic [1:0]  rxd, txd, rts_n, hfree, empty;
    logic [7:0]  rdata, rd_val;
    logic        irq;
    logic [10:0] frame [2];
    logic [7:0]  fcnt [2];
    int          mismatches = 0;
    int          check_count = 0;
    int          cycles = 0;
    always #4 clk = ~clk;
    always #80 ext = ~ext;
    serial_rts_baud_multidrop #(.RX_DEPTH(2)) i_dut (
        .I_SYS_CLK(clk), .I_SYS_RST(rst), .I_CE(1'b1), .I_REG(req), .O_RDATA(rdata), .O_IRQ(irq),
        .I_CRYSTAL_INPUT(1'b0), .I_EXT_BAUD_CLK(ext), .I_RXD(rxd), .I_RX_POP(pop), .O_TXD(txd),
        .O_REQUEST_TO_SEND_N(rts_n), .O_TRANSMIT_HOLDING_FREE(hfree), .O_TRANSMITTER_FULLY_EMPTY(empty)
    );
    remote_serial_peer i_peer (
        .i_clk(clk), .i_ext_baud(ext), .i_txd(txd), .i_send(send), .o_rxd(rxd), .o_frame(frame), .o_count(fcnt)
    );
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        if (++cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic check(input logic [10:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t mismatch got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
        tick(2);
    endtask : reg_wr
    task automatic reg_rd(input logic [11:0] a);
        @(posedge clk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 rd_val = rdata;
    endtask : reg_rd
    task automatic rx_op(input logic is_send);
        @(posedge clk);
        send <= {1'b0, is_send};
        pop <= {1'b0, !is_send};
        @(posedge clk);
        send <= 2'h0;
        pop <= 2'h0;
        tick(12);
    endtask : rx_op
    task automatic wait_free(input int c);
        tick(1);
        for (int i = 0; i < 400 && hfree[c] !== 1'b1; i++) tick(1);
    endtask : wait_free
    task automatic wait_frame(input int c, input logic [7:0] n);
        for (int i = 0; i < 5000 && fcnt[c] !== n; i++) tick(1);
    endtask : wait_frame
    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_reset();
        check(rts_n, 2'h3);
        reg_rd(IDX_STATUS);
        check(rd_val, 8'h03);
        reg_rd(12'h7FF);
        check(rd_val, 8'h00);
    endtask : test_reset
    task automatic test_out_regs();
        reg_wr(IDX_OUT_SET, 8'h01);
        check(rts_n, 2'h2);
        reg_wr(IDX_OUT_SET, 8'h02);
        check(rts_n, 2'h0);
        reg_wr(IDX_OUT_CLR, 8'h01);
        check(rts_n, 2'h1);
        reg_wr(IDX_OUT_CLR, 8'h02);
        check(rts_n, 2'h3);
        for (int c = 0; c < 2; c++) begin
            reg_wr(IDX_CMD_A + 12'(c), {1'b0, CMD_ASSERT_RTS, 4'h0});
            check(rts_n[c], 1'b0);
            reg_wr(IDX_CMD_A + 12'(c), {1'b0, CMD_NEGATE_RTS, 4'h0});
            check(rts_n[c], 1'b1);
        end
    endtask : test_out_regs
    task automatic test_rx_flow();
        reg_wr(IDX_MODE1_A, 8'h80);
        rx_op(1'b1);
        rx_op(1'b1);
        reg_rd(IDX_RX_LEVEL);
        check(rd_val, 8'h02);
        rx_op(1'b0);
        check(rts_n[0], 1'b0);
        rx_op(1'b1);
        check(rts_n[0], 1'b1);
        rx_op(1'b0);
        check(rts_n[0], 1'b0);
        rx_op(1'b0);
    endtask : test_rx_flow
    task automatic test_multidrop();
        reg_wr(IDX_CLKSEL, {2'h0, SRC_EXT_16X, 2'h0, SRC_EXT_1X});
        reg_wr(IDX_CMD_A, {1'b0, CMD_TX_ENABLE, 4'h0});
        reg_wr(IDX_MODE1_A, 8'h4C);
        reg_wr(IDX_OUT_SET, 8'h01);
        wait_free(0);
        reg_wr(IDX_TXDATA_A, 8'hA5);
        wait_free(0);
        reg_wr(IDX_MODE1_A, 8'h48);
        reg_wr(IDX_TXDATA_A, 8'h3C);
        wait_frame(0, 8'h01);
        check(frame[0], {2'h3, 8'hA5, 1'b0});
        wait_frame(0, 8'h02);
        check(frame[0], {2'h2, 8'h3C, 1'b0});
        check(rts_n[0], 1'b0);
        for (int i = 0; i < 200 && empty[0] !== 1'b1; i++) tick(1);
        tick(2);
        check(rts_n[0], 1'b1);
        reg_rd(IDX_IRQ_STAT);
        check(rd_val, 8'h03);
        reg_wr(IDX_IRQ_EN, 8'h02);
        check(irq, 1'b1);
        reg_wr(IDX_IRQ_CLR, 8'h02);
        check(irq, 1'b0);
        reg_wr(IDX_IRQ_EN, 8'h01);
        check(irq, 1'b1);
        reg_wr(IDX_IRQ_EN, 8'h00);
        check(irq, 1'b0);
    endtask : test_multidrop
    task automatic test_ext16();
        reg_wr(IDX_CMD_B, {1'b0, CMD_TX_ENABLE, 4'h0});
        reg_wr(IDX_MODE1_B, 8'h0C);
        wait_free(1);
        reg_wr(IDX_TXDATA_B, 8'h5A);
        wait_frame(1, 8'h01);
        check(frame[1], {2'h3, 8'h5A, 1'b0});
    endtask : test_ext16
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        test_reset();
        test_out_regs();
        test_rx_flow();
        test_multidrop();
        test_ext16();
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
